// [psmc_pkg.sv]
// Package for the processor status and mode control register bank
package psmc_pkg;

  // AXI4-Lite geometry
  localparam int unsigned ADDR_W = 8;             // Byte address width
  localparam int unsigned DATA_W = 32;            // Data width

  // Register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h00;  // Status and control
  localparam logic [ADDR_W-1:0] MODE_OFF   = 8'h04;  // Decoded mode view

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;      // Normal completion
  localparam logic [1:0] RESP_SLVERR = 2'h2;      // Unmapped address

  // Status word reset value: boot vectors and error level set
  localparam logic [31:0] STATUS_RST  = 32'h0040_0004;
  // Software writable bits; reserved positions stay zero
  localparam logic [31:0] STATUS_WMASK = 32'hF654_FFFF;

  // Privilege field encodings
  localparam logic [1:0] FLD_KERNEL = 2'h0;       // Kernel
  localparam logic [1:0] FLD_SUPER  = 2'h1;       // Supervisor
  localparam logic [1:0] FLD_USER   = 2'h2;       // User

  // Mode view field positions
  localparam int unsigned MV_PRIV_LSB = 0;        // Effective privilege
  localparam int unsigned MV_GIE_BIT  = 2;        // Global irq enable
  localparam int unsigned MV_END_BIT  = 3;        // Effective byte order
  localparam int unsigned MV_COP_LSB  = 4;        // Effective usability
  localparam int unsigned MV_TAKE_LSB = 8;        // Interrupts taken

  // Effective privilege
  typedef enum logic [1:0] {
    PRIV_KERNEL,
    PRIV_SUPER,
    PRIV_USER
  } psmc_priv_e;

  // Status word field layout, msb first
  typedef struct packed {
    logic [3:0] coproc_usable;     // 31:28
    logic       rsv27;             // 27
    logic       fpr_layout_sel;    // 26
    logic       user_endian_flip;  // 25
    logic [1:0] rsv24_23;          // 24:23
    logic       boot_vector_sel;   // 22
    logic       rsv21;             // 21
    logic       soft_reset_flag;   // 20
    logic       rsv19;             // 19
    logic       cache_hit_flag;    // 18
    logic [1:0] rsv17_16;          // 17:16
    logic [7:0] irq_mask;          // 15:8
    logic       kernel_wide_addr;  // 7
    logic       super_wide_en;     // 6
    logic       user_wide_en;      // 5
    logic [1:0] privilege_field;   // 4:3
    logic       error_level;       // 2
    logic       exception_level;   // 1
    logic       global_irq_en;     // 0
  } psmc_status_s;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } psmc_axi_req_s;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } psmc_axi_rsp_s;

  // Whole module state
  typedef struct packed {
    psmc_status_s      st;         // Status word
    logic              aw_got;     // Write address held
    logic [ADDR_W-1:0] awaddr;     // Held write address
    logic              w_got;      // Write data held
    logic [DATA_W-1:0] wdata;      // Held write data
    logic [3:0]        wstrb;      // Held strobes
    logic              bvalid;     // Write response pending
    logic [1:0]        bresp;      // Write response code
    logic              rvalid;     // Read data pending
    logic [DATA_W-1:0] rdata;      // Read data
    logic [1:0]        rresp;      // Read response code
  } psmc_state_s;

endpackage

// [psmc_status_ctrl.sv]
// Processor status and mode control register bank with AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1: Bits 31:28 coprocessor usable, reset zero
// RL2: Coprocessor zero always usable in kernel
// RL3: Bit 26 selects FP register layout
// RL4: Bit 25 flips byte order, user only
// RL5: Bit 22 selects bootstrap vectors, reset one
// RL6: Bit 20 set on soft reset/NMI
// RL7: Bit 18 records last hit-cache-op result
// RL8: Bits 15:8 mask; take needs mask, pending
// RL9: Global enable needs enable, no levels
// RL10: Bit 7 kernel 64-bit addressing, refill
// RL11: Bit 6 supervisor 64-bit, extended refill
// RL12: Bit 5 user 64-bit, extended refill
// RL13: Kernel always allows 64-bit operations
// RL14: Bits 4:3 privilege field, reset 00
// RL15: Effective privilege from field and levels
// RL16: Bits 2..0 error, exception, irq enable
// RL17: Address space access by privilege
// RL18: Reset forces error level, boot vectors
// RL19: Reserved bits read zero, ignore writes
module psmc_status_ctrl (
  input  wire logic                    clock_i,         // Core clock
  input  wire logic                    rstn_i,          // Sync reset, low
  input  wire psmc_pkg::psmc_axi_req_s axi_req_i,       // Bus requests
  output var  psmc_pkg::psmc_axi_rsp_s axi_rsp_o,       // Bus answers
  input  wire logic [7:0]              irq_pending_i,   // Pending sources
  input  wire logic                    soft_reset_evt_i, // Soft reset pulse
  input  wire logic                    nmi_evt_i,       // NMI pulse
  input  wire logic                    cache_op_i,      // Hit cache op done
  input  wire logic                    cache_hit_i,     // Its hit result
  input  wire logic                    cfg_big_endian_i, // Reset byte order
  output logic [1:0]                   priv_o,          // Effective mode
  output logic                         irq_enabled_o,   // Global enable
  output logic [7:0]                   irq_take_o,      // Sources taken
  output logic                         irq_req_o,       // Any source taken
  output logic [3:0]                   coproc_ok_o,     // Usable units
  output logic                         fpr_layout_o,    // FP layout select
  output logic                         big_endian_o,    // Effective order
  output logic                         boot_vec_o,      // Bootstrap vectors
  output logic                         wide_addr_o,     // 64-bit addressing
  output logic                         wide_ops_o,      // 64-bit operations
  output logic [2:0]                   xrefill_o,       // Ext refill k/s/u
  output logic [2:0]                   space_ok_o       // Access k/s/u
);
  import psmc_pkg::*;

  // Register selection decode, shared by write and read paths
  typedef enum logic [1:0] {
    SEL_STATUS,
    SEL_MODE,
    SEL_NONE
  } psmc_sel_e;

  function automatic psmc_sel_e psmc_decode(input logic [ADDR_W-1:0] a);
    psmc_sel_e s;
    s = SEL_NONE;
    if (a == STATUS_OFF) begin
      s = SEL_STATUS;
    end else if (a == MODE_OFF) begin
      s = SEL_MODE;
    end
    return s;
  endfunction

  // Effective privilege from the status word
  function automatic psmc_priv_e psmc_priv(input psmc_status_s s);
    psmc_priv_e p;
    p = PRIV_KERNEL;
    if (!s.error_level && !s.exception_level) begin
      if (s.privilege_field == FLD_USER) begin
        p = PRIV_USER;
      end else if (s.privilege_field == FLD_SUPER) begin
        p = PRIV_SUPER;
      end
    end
    return p;
  endfunction

  psmc_state_s   q;        // Registered state
  psmc_state_s   d;        // Next state
  psmc_priv_e    priv;     // Current effective privilege
  logic          gie;      // Global interrupt enable
  logic          aw_hs;    // Write address handshake
  logic          w_hs;     // Write data handshake
  logic          ar_hs;    // Read address handshake
  logic [31:0]   mode_word; // Decoded mode view
  logic [31:0]   bmask;    // Byte enable mask

  // Privilege and interrupt enabling
  always_comb begin
    priv = psmc_priv(q.st);                                   // see RL15
    gie  = q.st.global_irq_en && !q.st.exception_level
           && !q.st.error_level;                              // see RL9
  end

  // Mode outputs derived from the status word
  always_comb begin
    priv_o        = priv;
    irq_enabled_o = gie;
    irq_take_o    = gie ? (q.st.irq_mask & irq_pending_i) : 8'h00; // see RL8
    irq_req_o     = |irq_take_o;
    coproc_ok_o   = q.st.coproc_usable;                       // see RL1
    coproc_ok_o[0] = q.st.coproc_usable[0] || (priv == PRIV_KERNEL); // see RL2
    fpr_layout_o  = q.st.fpr_layout_sel;                      // see RL3
    big_endian_o  = cfg_big_endian_i ^
                    (q.st.user_endian_flip && priv == PRIV_USER); // see RL4
    boot_vec_o    = q.st.boot_vector_sel;                     // see RL5
    xrefill_o     = {q.st.kernel_wide_addr, q.st.super_wide_en,
                     q.st.user_wide_en};                      // see RL10
    unique case (priv)
      PRIV_KERNEL: begin
        wide_addr_o = q.st.kernel_wide_addr;                  // see RL10
        wide_ops_o  = 1'b1;                                   // see RL13
      end
      PRIV_SUPER: begin
        wide_addr_o = q.st.super_wide_en;                     // see RL11
        wide_ops_o  = q.st.super_wide_en;
      end
      PRIV_USER: begin
        wide_addr_o = q.st.user_wide_en;                      // see RL12
        wide_ops_o  = q.st.user_wide_en;
      end
      default: begin
        wide_addr_o = 1'b0;
        wide_ops_o  = 1'b0;
      end
    endcase
    // Kernel, supervisor, user space permissions
    space_ok_o = {priv == PRIV_KERNEL,
                  priv != PRIV_USER,
                  1'b1};                                      // see RL17
  end

  // Read-only view of the decoded mode
  always_comb begin
    mode_word = 32'h0000_0000;
    mode_word[MV_PRIV_LSB +: 2] = priv;
    mode_word[MV_GIE_BIT]       = gie;
    mode_word[MV_END_BIT]       = big_endian_o;
    mode_word[MV_COP_LSB +: 4]  = coproc_ok_o;
    mode_word[MV_TAKE_LSB +: 8] = irq_take_o;
  end

  // Bus handshakes: accept one write and one read at a time
  always_comb begin
    axi_rsp_o.awready = !q.aw_got && !q.bvalid;
    axi_rsp_o.wready  = !q.w_got && !q.bvalid;
    axi_rsp_o.bvalid  = q.bvalid;
    axi_rsp_o.bresp   = q.bresp;
    axi_rsp_o.arready = !q.rvalid;
    axi_rsp_o.rvalid  = q.rvalid;
    axi_rsp_o.rdata   = q.rdata;
    axi_rsp_o.rresp   = q.rresp;
    aw_hs = axi_req_i.awvalid && axi_rsp_o.awready;
    w_hs  = axi_req_i.wvalid && axi_rsp_o.wready;
    ar_hs = axi_req_i.arvalid && axi_rsp_o.arready;
  end

  // Next state: bus write, hardware events, read capture
  always_comb begin
    logic [ADDR_W-1:0] wa;     // Effective write address
    logic [31:0]       wd;     // Effective write data
    logic [3:0]        ws;     // Effective strobes
    logic [31:0]       cur;    // Current status word
    d   = q;
    wa  = q.aw_got ? q.awaddr : axi_req_i.awaddr;
    wd  = q.w_got ? q.wdata : axi_req_i.wdata;
    ws  = q.w_got ? q.wstrb : axi_req_i.wstrb;
    cur = q.st;
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{ws[i]}};
    end
    // Hold whichever half of a write arrives first
    if (aw_hs) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req_i.awaddr;
    end
    if (w_hs) begin
      d.w_got = 1'b1;
      d.wdata = axi_req_i.wdata;
      d.wstrb = axi_req_i.wstrb;
    end
    // Both halves present: perform the write and answer
    if ((q.aw_got || aw_hs) && (q.w_got || w_hs)) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      unique case (psmc_decode(wa))
        SEL_STATUS: begin
          // Only writable, enabled bytes change; reserved bits stay 0
          d.st = (cur & ~(STATUS_WMASK & bmask)) |
                 (wd & STATUS_WMASK & bmask);                 // see RL19
        end
        SEL_MODE: begin
          d.bresp = RESP_OKAY;     // Read-only view, write ignored
        end
        default: begin
          d.bresp = RESP_SLVERR;   // Unmapped address
        end
      endcase
    end
    if (q.bvalid && axi_req_i.bready) begin
      d.bvalid = 1'b0;
    end
    // Hardware updates win over a same-cycle software write
    if (soft_reset_evt_i || nmi_evt_i) begin
      d.st.soft_reset_flag = 1'b1;                            // see RL6
    end
    if (cache_op_i) begin
      d.st.cache_hit_flag = cache_hit_i;                      // see RL7
    end
    // Read path
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      unique case (psmc_decode(axi_req_i.araddr))
        SEL_STATUS: begin
          d.rdata = q.st;                                     // see RL16
        end
        SEL_MODE: begin
          d.rdata = mode_word;
        end
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && axi_req_i.rready) begin
      d.rvalid = 1'b0;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      q        <= '0;
      q.st     <= STATUS_RST;                      // see RL18, RL14
    end else begin
      q <= d;
    end
  end

  // Checks

  property p_reset_vals;
    @(posedge clock_i) disable iff (!rstn_i)
      $past(!rstn_i) |-> (q.st == STATUS_RST && q.st.error_level &&
                          q.st.boot_vector_sel);
  endproperty
  a_reset_vals: assert property (p_reset_vals) // see RL18
    else $error("status word not at reset value after reset");

  property p_cu0_kernel;
    @(posedge clock_i) disable iff (!rstn_i)
      (q.st.error_level || q.st.exception_level ||
       q.st.privilege_field == FLD_KERNEL) |-> coproc_ok_o[0];
  endproperty
  a_cu0_kernel: assert property (p_cu0_kernel) // see RL2
    else $error("coprocessor zero unusable in kernel mode");

  property p_endian;
    @(posedge clock_i) disable iff (!rstn_i)
      (priv_o != PRIV_USER) |-> (big_endian_o == cfg_big_endian_i);
  endproperty
  a_endian: assert property (p_endian) // see RL4
    else $error("byte order flipped outside user mode");

  property p_sr_set;
    @(posedge clock_i) disable iff (!rstn_i)
      (soft_reset_evt_i || nmi_evt_i) |=> q.st.soft_reset_flag;
  endproperty
  a_sr_set: assert property (p_sr_set) // see RL6
    else $error("soft reset flag not set after event");

  property p_cache_hit;
    @(posedge clock_i) disable iff (!rstn_i)
      cache_op_i |=> (q.st.cache_hit_flag == $past(cache_hit_i));
  endproperty
  a_cache_hit: assert property (p_cache_hit) // see RL7
    else $error("cache hit flag does not follow last operation");

  property p_irq_take;
    @(posedge clock_i) disable iff (!rstn_i)
      (q.st.exception_level || q.st.error_level || !q.st.global_irq_en)
        |-> (irq_take_o == 8'h00 && !irq_req_o);
  endproperty
  a_irq_take: assert property (p_irq_take) // see RL9
    else $error("interrupt taken while globally disabled");

  property p_priv;
    @(posedge clock_i) disable iff (!rstn_i)
      (q.st.exception_level || q.st.error_level) |-> priv_o == PRIV_KERNEL;
  endproperty
  a_priv: assert property (p_priv) // see RL15
    else $error("non-kernel privilege with a level bit set");

  property p_space;
    @(posedge clock_i) disable iff (!rstn_i)
      (priv_o == PRIV_USER) |-> (space_ok_o == 3'h1);
  endproperty
  a_space: assert property (p_space) // see RL17
    else $error("user mode granted privileged space");

  property p_ops64;
    @(posedge clock_i) disable iff (!rstn_i)
      (priv_o == PRIV_KERNEL) |->
        (wide_ops_o && wide_addr_o == q.st.kernel_wide_addr);
  endproperty
  a_ops64: assert property (p_ops64) // see RL13
    else $error("kernel 64-bit operation or addressing wrong");

  property p_rsv_zero;
    @(posedge clock_i) disable iff (!rstn_i)
      ((q.st & ~STATUS_WMASK) == 32'h0000_0000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // see RL19
    else $error("reserved status bit is non-zero");

  property p_wr_resp;
    @(posedge clock_i) disable iff (!rstn_i)
      (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid &&
       axi_rsp_o.wready) |=> axi_rsp_o.bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing one cycle after write");

  c_write:   cover property (@(posedge clock_i) disable iff (!rstn_i)
    axi_rsp_o.bvalid && axi_req_i.bready);
  c_read:    cover property (@(posedge clock_i) disable iff (!rstn_i)
    axi_rsp_o.rvalid && axi_req_i.rready);
  c_irq:     cover property (@(posedge clock_i) disable iff (!rstn_i)
    irq_req_o);
  c_user:    cover property (@(posedge clock_i) disable iff (!rstn_i)
    priv_o == PRIV_USER);

endmodule

`default_nettype wire

// [tb.sv]
// Self-checking bench for the status and mode control register bank
`timescale 1ns/10ps
`default_nettype none

module tb;
  import psmc_pkg::*;

  logic          clock_i;      // Core clock
  logic          rstn_i;       // Sync reset, low
  psmc_axi_req_s req;          // Bus requests
  psmc_axi_rsp_s rsp;          // Bus answers
  logic [7:0]    pend;         // Pending sources
  logic          soft_evt;     // Soft reset pulse
  logic          nmi_evt;      // NMI pulse
  logic          c_op;         // Cache op done
  logic          c_hit;        // Cache op result
  logic          cfg_be;       // Configured byte order
  logic [1:0]    priv;         // Effective privilege
  logic          irq_en;       // Global enable
  logic [7:0]    take;         // Sources taken
  logic          irq_req;      // Any source taken
  logic [3:0]    cop_ok;       // Usable units
  logic          fpr;          // FP layout
  logic          big_end;      // Effective byte order
  logic          bootv;        // Bootstrap vectors
  logic          waddr;        // 64-bit addressing
  logic          wops;         // 64-bit operations
  logic [2:0]    xref;         // Extended refill k/s/u
  logic [2:0]    space;        // Space access k/s/u
  int            fails;        // Mismatch count
  int            checks_done;  // Comparison count

  psmc_status_ctrl dut_u (
    .clock_i          (clock_i),
    .rstn_i           (rstn_i),
    .axi_req_i        (req),
    .axi_rsp_o        (rsp),
    .irq_pending_i    (pend),
    .soft_reset_evt_i (soft_evt),
    .nmi_evt_i        (nmi_evt),
    .cache_op_i       (c_op),
    .cache_hit_i      (c_hit),
    .cfg_big_endian_i (cfg_be),
    .priv_o           (priv),
    .irq_enabled_o    (irq_en),
    .irq_take_o       (take),
    .irq_req_o        (irq_req),
    .coproc_ok_o      (cop_ok),
    .fpr_layout_o     (fpr),
    .big_endian_o     (big_end),
    .boot_vec_o       (bootv),
    .wide_addr_o      (waddr),
    .wide_ops_o       (wops),
    .xrefill_o        (xref),
    .space_ok_o       (space)
  );

  // Clock of 8 ns period
  always #4 clock_i = ~clock_i;

  // Prints counts and verdict, then ends the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value, four-state exact
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic       aw_hit;
    logic       w_hit;
    logic       b_hit;
    logic [1:0] resp;
    @(posedge clock_i);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      // Settled values just before the sampling edge
      @(negedge clock_i);
      aw_hit = req.awvalid & rsp.awready;
      w_hit  = req.wvalid & rsp.wready;
      b_hit  = (rsp.bvalid === 1'b1);
      resp   = rsp.bresp;
      @(posedge clock_i);
      if (aw_hit) req.awvalid <= 1'b0;
      if (w_hit) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  // Bus read with expected data and response
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] ed, input logic [1:0] er);
    logic        ar_hit;
    logic        r_hit;
    logic [31:0] d;
    logic [1:0]  resp;
    @(posedge clock_i);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge clock_i);
      ar_hit = req.arvalid & rsp.arready;
      r_hit  = (rsp.rvalid === 1'b1);
      d      = rsp.rdata;
      resp   = rsp.rresp;
      @(posedge clock_i);
      if (ar_hit) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    chk(nm, ed, d);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  // One-cycle event pulse on the hardware inputs
  task automatic ev(input logic s, input logic n, input logic o,
                    input logic h);
    @(posedge clock_i);
    soft_evt <= s;
    nmi_evt <= n;
    c_op    <= o;
    c_hit   <= h;
    @(posedge clock_i);
    soft_evt <= 1'b0;
    nmi_evt <= 1'b0;
    c_op    <= 1'b0;
  endtask

  // One combination of field, levels, wide enables and byte order
  task automatic mode_case(input int i);
    logic [31:0] w;
    logic [3:0]  cv;
    logic        lv;
    logic        k;
    logic        s;
    logic        u;
    logic        x;
    logic [1:0]  pr;
    logic [7:0]  tk;
    logic [3:0]  ok;
    logic        be;
    x  = i[4];
    cv = {i[3:1], 1'b0};
    w  = {cv, 2'h0, x, 9'h0, 8'hA5, x, ~x, x, i[1:0], i[3], i[2], 1'b1};
    @(posedge clock_i);
    cfg_be <= i[0];
    pend   <= 8'h3C;
    wr(STATUS_OFF, w, 4'hF, RESP_OKAY);
    lv = i[2] | i[3];
    u  = !lv && i[1:0] == 2'h2;
    s  = !lv && i[1:0] == 2'h1;
    k  = !u && !s;
    pr = u ? 2'h2 : (s ? 2'h1 : 2'h0);
    tk = lv ? 8'h00 : (8'hA5 & 8'h3C);
    ok = cv | {3'h0, k};
    be = i[0] ^ (x & u);
    @(negedge clock_i);
    chk("priv", {30'h0, pr}, {30'h0, priv});
    chk("irq_en", {31'h0, !lv}, {31'h0, irq_en});
    chk("take", {24'h0, tk}, {24'h0, take});
    chk("irq_req", {31'h0, |tk}, {31'h0, irq_req});
    chk("cop_ok", {28'h0, ok}, {28'h0, cop_ok});
    chk("big_end", {31'h0, be}, {31'h0, big_end});
    chk("waddr", {31'h0, k ? x : (s ? ~x : x)}, {31'h0, waddr});
    chk("wops", {31'h0, k | (s ? ~x : x)}, {31'h0, wops});
    chk("xref", {29'h0, x, ~x, x}, {29'h0, xref});
    chk("space", {29'h0, k, !u, 1'b1}, {29'h0, space});
    rdchk("status", STATUS_OFF, w, RESP_OKAY);
    rdchk("mode", MODE_OFF, {16'h0, tk, ok, be, !lv, pr},
          RESP_OKAY);
  endtask

  // Inputs at time zero
  initial begin
    clock_i = 1'b0;
    rstn_i  = 1'b0;
    req     = '0;
    pend    = 8'h00;
    soft_evt = 1'b0;
    nmi_evt = 1'b0;
    c_op    = 1'b0;
    c_hit   = 1'b0;
    cfg_be  = 1'b0;
    fails   = 0;
    checks_done = 0;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(negedge clock_i);
    chk("rst_priv", 32'h0, {30'h0, priv});
    chk("rst_cop_ok", 32'h1, {28'h0, cop_ok});
    chk("rst_boot", 32'h1, {31'h0, bootv});
    chk("rst_wops", 32'h1, {31'h0, wops});
    chk("rst_space", 32'h7, {29'h0, space});
    rdchk("rst_status", STATUS_OFF, 32'h0040_0004, RESP_OKAY);
    // All ones: reserved bits stay zero, fp layout goes to one
    wr(STATUS_OFF, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rdchk("status", STATUS_OFF, 32'hF654_FFFF, RESP_OKAY);
    chk("fpr", 32'h1, {31'h0, fpr});
    chk("priv_rsv", 32'h0, {30'h0, priv});
    // Byte strobes write only their lane
    wr(STATUS_OFF, 32'h0, 4'hF, RESP_OKAY);
    chk("boot_clr", 32'h0, {31'h0, bootv});
    chk("fpr_clr", 32'h0, {31'h0, fpr});
    wr(STATUS_OFF, 32'hFFFF_FFFF, 4'h2, RESP_OKAY);
    rdchk("strb", STATUS_OFF, 32'h0000_FF00, RESP_OKAY);
    // Read-only view and unmapped place leave the word alone
    wr(MODE_OFF, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    wr(8'h08, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    rdchk("unmapped", 8'h08, 32'h0, RESP_SLVERR);
    rdchk("kept", STATUS_OFF, 32'h0000_FF00, RESP_OKAY);
    // Soft reset and NMI flag, cache hit flag
    wr(STATUS_OFF, 32'h0, 4'hF, RESP_OKAY);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    rdchk("soft_rst", STATUS_OFF, 32'h0010_0000, RESP_OKAY);
    wr(STATUS_OFF, 32'h0, 4'hF, RESP_OKAY);
    ev(1'b0, 1'b1, 1'b0, 1'b0);
    rdchk("nmi", STATUS_OFF, 32'h0010_0000, RESP_OKAY);
    ev(1'b0, 1'b0, 1'b1, 1'b1);
    rdchk("hit", STATUS_OFF, 32'h0014_0000, RESP_OKAY);
    ev(1'b0, 1'b0, 1'b1, 1'b0);
    rdchk("miss", STATUS_OFF, 32'h0010_0000, RESP_OKAY);
    // Every field code with both levels and wide bits; byte order follows field bit 0
    for (int i = 0; i < 32; i++) begin
      mode_case(i);
    end
    // Reset in mid-run brings back error level and boot vectors
    @(posedge clock_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    rdchk("rerst", STATUS_OFF, 32'h0040_0004, RESP_OKAY);
    chk("rerst_boot", 32'h1, {31'h0, bootv});
    stop_test;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    stop_test;
  end

endmodule

`default_nettype wire
